// ### core/hbp_pkg.sv
// Behaviour
// - Latch transparent while address strobe high
// - Falling address strobe captures and holds address
// - Non-multiplexed host keeps address strobe high
// - Select held low for whole access
// - Separate read/write strobes give access type
// - Data strobe plus direction line, high reads
// - Ready low when cycle may proceed
// - Ready undriven in reset or deselected
// - Interrupt low on enabled pending event
// - Idle interrupt drives high or floats, floats
// - Reset disables sources, interrupt undriven
// - Strobe-style select: one means data strobe
// - Bus-size select: one means 16 bits
// - Interface select: one means serial, parallel off
// - Narrow bus: low address bit picks byte
// - Wide bus: swap input exchanges byte lanes
package hbp_pkg;
    localparam int HBP_AW = 9;
    localparam int HBP_DW = 16;
    // Device internal word addresses (address bits 8:1)
    localparam logic [7:0] HBP_DEV_ISTAT = 8'hFD;
    localparam logic [7:0] HBP_DEV_IEN = 8'hFE;
    localparam logic [7:0] HBP_DEV_ICTL = 8'hFF;
    localparam int HBP_ICTL_DRV = 0;
    localparam logic HBP_IDRV_RST = 1'b0;
    // Host controller Wishbone byte offsets
    localparam logic [7:0] HBP_WB_CTRL = 8'h00;
    localparam logic [7:0] HBP_WB_ADDR = 8'h04;
    localparam logic [7:0] HBP_WB_WDATA = 8'h08;
    localparam logic [7:0] HBP_WB_CMD = 8'h0C;
    localparam logic [7:0] HBP_WB_RDATA = 8'h10;
    localparam logic [7:0] HBP_WB_ISTAT = 8'h14;
    localparam logic [7:0] HBP_WB_IMASK = 8'h18;
    localparam int HBP_CTRL_MODE = 0;
    localparam int HBP_CTRL_WIDTH = 1;
    localparam int HBP_CTRL_SWAP = 2;
    localparam int HBP_CTRL_SPI = 3;
    localparam int HBP_CTRL_MUX = 4;
    localparam int HBP_CTRL_W = 5;
    localparam logic [HBP_CTRL_W-1:0] HBP_CTRL_RST = 5'h00;
    localparam int HBP_CMD_START = 0;
    localparam int HBP_CMD_READ = 1;
    localparam int HBP_IRQ_DONE = 0;
    localparam int HBP_IRQ_DEV = 1;
    typedef enum logic [2:0] {
        HBP_D_IDLE = 3'b001,
        HBP_D_REQ = 3'b010,
        HBP_D_DONE = 3'b100
    } hbp_dev_st_e;
    typedef enum logic [3:0] {
        HBP_H_IDLE = 4'b0001,
        HBP_H_SETUP = 4'b0010,
        HBP_H_STRB = 4'b0100,
        HBP_H_RELS = 4'b1000
    } hbp_host_st_e;
endpackage : hbp_pkg

// ### core/hbp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hbp_if;
    import hbp_pkg::*;
    logic [HBP_AW-1:0] addr;
    logic ale;
    logic cs_n;
    logic rd_or_data_strobe_n;
    logic wr_n_or_dir;
    logic mode;
    logic width;
    logic spi;
    logic [HBP_DW-1:0] host_d_o;
    logic [1:0] host_d_oe;
    logic [HBP_DW-1:0] dev_d_o;
    logic [1:0] dev_d_oe;
    logic [HBP_DW-1:0] d;
    logic dev_rdy_o;
    logic dev_rdy_oe;
    logic rdy_n;
    logic dev_int_o;
    logic dev_int_oe;
    logic int_n;
    // Wire levels: pulled high where nobody drives
    assign d[7:0] = dev_d_oe[0] ? dev_d_o[7:0] : (host_d_oe[0] ? host_d_o[7:0] : 8'hFF);
    assign d[15:8] = dev_d_oe[1] ? dev_d_o[15:8] : (host_d_oe[1] ? host_d_o[15:8] : 8'hFF);
    assign rdy_n = dev_rdy_oe ? dev_rdy_o : 1'b1;
    assign int_n = dev_int_oe ? dev_int_o : 1'b1;
    modport dev (
        input addr, ale, cs_n, rd_or_data_strobe_n, wr_n_or_dir, mode, width, spi, d,
        output dev_d_o, dev_d_oe, dev_rdy_o, dev_rdy_oe, dev_int_o, dev_int_oe
    );
    modport host (
        output addr, ale, cs_n, rd_or_data_strobe_n, wr_n_or_dir, mode, width, spi,
        output host_d_o, host_d_oe,
        input d, rdy_n, int_n
    );
endinterface : hbp_if
`default_nettype wire

// ### core/hbp_dev.sv
`timescale 1ns/100ps
`default_nettype none
module hbp_dev #(
    parameter int N_IRQ = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    hbp_if.dev bus,
    output logic [7:0] usr_addr,
    output logic usr_rd,
    output logic usr_wr,
    output logic [hbp_pkg::HBP_DW-1:0] usr_wdata,
    output logic [1:0] usr_be,
    input wire logic [hbp_pkg::HBP_DW-1:0] usr_rdata,
    input wire logic usr_ack,
    input wire logic [N_IRQ-1:0] irq_event
);
    import hbp_pkg::*;

    typedef struct packed {
        hbp_dev_st_e st;
        // Two-flop synchronisers for select and strobes
        logic cs_m;
        logic cs_s;
        logic rd_m;
        logic rd_s;
        logic wr_m;
        logic wr_s;
        // Address latch and the access captured at its start
        logic [HBP_AW-1:0] alatch;
        logic is_rd;
        logic is_int;
        logic [7:0] waddr;
        logic a0;
        logic wide;
        logic [HBP_DW-1:0] wdata;
        logic [1:0] be;
        logic [HBP_DW-1:0] dout;
        // Interrupt status, enables and idle drive choice
        logic [N_IRQ-1:0] istat;
        logic [N_IRQ-1:0] ien;
        logic idrv;
    } hbp_dev_s;

    localparam hbp_dev_s DEV_RST = '{
        st: HBP_D_IDLE,
        cs_m: 1'b1,
        cs_s: 1'b1,
        rd_m: 1'b1,
        rd_s: 1'b1,
        wr_m: 1'b1,
        wr_s: 1'b1,
        idrv: HBP_IDRV_RST,
        default: '0
    };

    hbp_dev_s state_reg;
    hbp_dev_s state_next;
    logic [HBP_AW-1:0] addr_eff;
    logic active;
    logic rd_req;
    logic pending;
    logic drive_rd;
    logic [HBP_DW-1:0] bemask;
    logic [HBP_DW-1:0] rsel;
    logic [HBP_DW-1:0] lanes;
    logic [N_IRQ-1:0] clr;
    logic strobe_on;
    logic hit_int;
    logic [HBP_DW-1:0] wlanes;
    logic [1:0] wbe;
    logic [HBP_DW-1:0] ireg;

    assign addr_eff = bus.ale ? bus.addr : state_reg.alatch;
    // Which strobe marks an access depends on the strobe style
    assign strobe_on = bus.mode ? ~state_reg.rd_s :
        (~state_reg.rd_s | ~state_reg.wr_s);
    assign active = ~state_reg.cs_s & ~bus.spi & strobe_on;
    assign rd_req = bus.mode ? state_reg.wr_s : ~state_reg.rd_s;
    assign hit_int = (addr_eff[HBP_AW-1:1] == HBP_DEV_ISTAT) ||
        (addr_eff[HBP_AW-1:1] == HBP_DEV_IEN) ||
        (addr_eff[HBP_AW-1:1] == HBP_DEV_ICTL);
    assign bemask = {{8{state_reg.be[1]}}, {8{state_reg.be[0]}}};

    // Write data and byte enables steered onto register bit positions
    always_comb begin
        wlanes = '0;
        wbe = 2'h0;
        if (bus.width) begin
            wlanes = addr_eff[0] ? {bus.d[7:0], bus.d[15:8]} : bus.d;
            wbe = 2'h3;
        end else if (addr_eff[0]) begin
            wlanes = {bus.d[7:0], 8'h00};
            wbe = 2'h2;
        end else begin
            wlanes = {8'h00, bus.d[7:0]};
            wbe = 2'h1;
        end
    end

    // Read view of the internal interrupt registers
    always_comb begin
        case (state_reg.waddr)
            HBP_DEV_ISTAT: ireg = HBP_DW'(state_reg.istat);
            HBP_DEV_IEN: ireg = HBP_DW'(state_reg.ien);
            HBP_DEV_ICTL: ireg = HBP_DW'(state_reg.idrv);
            default: ireg = '0;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        rsel = '0;
        lanes = '0;
        clr = '0;
        // Strobes and select pass two flops before use
        state_next.cs_m = bus.cs_n;
        state_next.cs_s = state_reg.cs_m;
        state_next.rd_m = bus.rd_or_data_strobe_n;
        state_next.rd_s = state_reg.rd_m;
        state_next.wr_m = bus.wr_n_or_dir;
        state_next.wr_s = state_reg.wr_m;

        // Latch follows the pins while ale is high and holds once it falls
        if (bus.ale) begin
            state_next.alatch = bus.addr;
        end
        case (state_reg.st)
            HBP_D_IDLE: begin
                if (active) begin
                    state_next.is_rd = rd_req;
                    state_next.waddr = addr_eff[HBP_AW-1:1];
                    state_next.a0 = addr_eff[0];
                    state_next.wide = bus.width;
                    state_next.is_int = hit_int;
                    state_next.wdata = wlanes;
                    state_next.be = wbe;
                    state_next.st = HBP_D_REQ;
                end
            end
            HBP_D_REQ: begin
                // Internal registers answer at once, user registers on usr_ack
                if (state_reg.is_int) begin
                    rsel = ireg;
                    if (!state_reg.is_rd) begin
                        case (state_reg.waddr)
                            HBP_DEV_ISTAT: clr = N_IRQ'(state_reg.wdata & bemask);
                            HBP_DEV_IEN: state_next.ien =
                                N_IRQ'((HBP_DW'(state_reg.ien) & ~bemask) | (state_reg.wdata & bemask));
                            default: begin
                                if (state_reg.be[0]) begin
                                    state_next.idrv = state_reg.wdata[HBP_ICTL_DRV];
                                end
                            end
                        endcase
                    end
                    state_next.st = HBP_D_DONE;
                end else if (usr_ack) begin
                    rsel = usr_rdata;
                    state_next.st = HBP_D_DONE;
                end
                // Read data placed on the lanes that width and address pick
                lanes = state_reg.a0 ? {rsel[7:0], rsel[15:8]} : rsel;
                state_next.dout = lanes;
            end
            HBP_D_DONE: begin
                // Stay until the strobe is seen released, so each access acts once
                if (!active) begin
                    state_next.st = HBP_D_IDLE;
                end
            end
            default: state_next.st = HBP_D_IDLE;
        endcase
        // A new event wins over a clear in the same cycle
        state_next.istat = (state_reg.istat & ~clr) | irq_event;
    end

    always_ff @(posedge clk) begin
        // Reset is checked before the clock enable
        if (!reset_n) begin
            state_reg <= DEV_RST;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign pending = |(state_reg.istat & state_reg.ien);
    // Data and ready pin enables follow reset and select directly, the interrupt enable reset only, so the pins float at once
    assign drive_rd = reset_n & ~bus.cs_n & ~bus.spi & ~bus.rd_or_data_strobe_n &
        (state_reg.st == HBP_D_DONE) & state_reg.is_rd;

    assign bus.dev_d_o = state_reg.dout;
    assign bus.dev_d_oe = {drive_rd & state_reg.wide, drive_rd};
    assign bus.dev_rdy_o = (state_reg.st != HBP_D_DONE);
    assign bus.dev_rdy_oe = reset_n & ~bus.cs_n & ~bus.spi;
    assign bus.dev_int_o = ~pending;
    assign bus.dev_int_oe = reset_n & (pending | state_reg.idrv);

    // User register port: the request stands in REQ until acknowledged
    assign usr_addr = state_reg.waddr;
    assign usr_rd = (state_reg.st == HBP_D_REQ) & ~state_reg.is_int & state_reg.is_rd;
    assign usr_wr = (state_reg.st == HBP_D_REQ) & ~state_reg.is_int & ~state_reg.is_rd;
    assign usr_wdata = state_reg.wdata;
    assign usr_be = state_reg.be;
endmodule : hbp_dev
`default_nettype wire

// ### core/hbp_host.sv
`timescale 1ns/100ps
`default_nettype none
module hbp_host (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    hbp_if.host bus,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq
);
    import hbp_pkg::*;

    typedef struct packed {
        hbp_host_st_e st;
        logic [HBP_CTRL_W-1:0] ctrl;
        logic [HBP_AW-1:0] addr;
        logic [HBP_DW-1:0] wdata;
        logic [HBP_DW-1:0] rdata;
        logic rd;
        logic [1:0] istat;
        logic [1:0] imask;
        logic ack;
        logic [31:0] dat;
        logic cs_n;
        logic strb_n;
        logic wr_pin;
        logic ale;
        logic [1:0] d_oe;
    } hbp_host_s;

    localparam hbp_host_s HOST_RST = '{st: HBP_H_IDLE, ctrl: HBP_CTRL_RST, cs_n: 1'b1,
        strb_n: 1'b1, wr_pin: 1'b1, ale: 1'b1, default: '0};

    hbp_host_s state_reg;
    hbp_host_s state_next;
    logic access;
    logic commit;
    logic [HBP_AW-1:0] addr_pin;
    logic [HBP_DW-1:0] wmask;
    logic [1:0] set;
    logic [1:0] clr;
    logic mode;

    assign access = wb_cyc_i & wb_stb_i & ~state_reg.ack;
    // Writes act at the edge where the master sees ack
    assign commit = wb_cyc_i & wb_stb_i & wb_we_i & state_reg.ack;
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign mode = state_reg.ctrl[HBP_CTRL_MODE];

    always_comb begin
        state_next = state_reg;
        set = '0;
        clr = '0;
        state_next.ack = access;
        state_next.dat = '0;
        if (access && !wb_we_i) begin
            case (wb_adr_i)
                HBP_WB_CTRL: state_next.dat = 32'(state_reg.ctrl);
                HBP_WB_ADDR: state_next.dat = 32'(state_reg.addr);
                HBP_WB_WDATA: state_next.dat = 32'(state_reg.wdata);
                HBP_WB_CMD: state_next.dat = 32'(state_reg.st != HBP_H_IDLE);
                HBP_WB_RDATA: state_next.dat = 32'(state_reg.rdata);
                HBP_WB_ISTAT: state_next.dat = 32'(state_reg.istat);
                HBP_WB_IMASK: state_next.dat = 32'(state_reg.imask);
                default: state_next.dat = '0;
            endcase
        end
        if (commit && wb_sel_i[0]) begin
            case (wb_adr_i)
                HBP_WB_CTRL: state_next.ctrl = wb_dat_i[HBP_CTRL_W-1:0];
                HBP_WB_ISTAT: clr = wb_dat_i[1:0];
                HBP_WB_IMASK: state_next.imask = wb_dat_i[1:0];
                default: state_next.ctrl = state_reg.ctrl;
            endcase
        end
        if (commit) begin
            case (wb_adr_i)
                HBP_WB_ADDR: state_next.addr =
                    HBP_AW'((32'(state_reg.addr) & ~32'(wmask)) | (wb_dat_i & 32'(wmask)));
                HBP_WB_WDATA: state_next.wdata = (state_reg.wdata & ~wmask) | (wb_dat_i[15:0] & wmask);
                default: state_next.wdata = state_reg.wdata;
            endcase
        end
        case (state_reg.st)
            HBP_H_IDLE: begin
                state_next.cs_n = 1'b1;
                state_next.ale = 1'b1;
                if (commit && wb_sel_i[0] && (wb_adr_i == HBP_WB_CMD) &&
                    wb_dat_i[HBP_CMD_START]) begin
                    state_next.rd = wb_dat_i[HBP_CMD_READ];
                    state_next.cs_n = 1'b0;
                    state_next.wr_pin = mode ? wb_dat_i[HBP_CMD_READ] : 1'b1;
                    state_next.d_oe = wb_dat_i[HBP_CMD_READ] ? 2'h0 :
                        {state_reg.ctrl[HBP_CTRL_WIDTH], 1'b1};
                    state_next.st = HBP_H_SETUP;
                end
            end
            HBP_H_SETUP: begin
                state_next.ale = ~state_reg.ctrl[HBP_CTRL_MUX];
                state_next.strb_n = mode ? 1'b0 : ~state_reg.rd;
                if (!mode) begin
                    state_next.wr_pin = state_reg.rd;
                end
                state_next.st = HBP_H_STRB;
            end
            HBP_H_STRB: begin
                if (!bus.rdy_n) begin
                    if (state_reg.rd) begin
                        state_next.rdata = bus.d;
                    end
                    state_next.strb_n = 1'b1;
                    state_next.wr_pin = mode ? state_reg.wr_pin : 1'b1;
                    state_next.st = HBP_H_RELS;
                end
            end
            HBP_H_RELS: begin
                // Select stays low until the device takes ready back
                if (bus.rdy_n) begin
                    state_next.cs_n = 1'b1;
                    state_next.d_oe = 2'h0;
                    state_next.ale = 1'b1;
                    set[HBP_IRQ_DONE] = 1'b1;
                    state_next.st = HBP_H_IDLE;
                end
            end
            default: state_next.st = HBP_H_IDLE;
        endcase
        set[HBP_IRQ_DEV] = ~bus.int_n;
        state_next.istat = (state_reg.istat & ~clr) | set;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= HOST_RST;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign addr_pin = state_reg.ctrl[HBP_CTRL_WIDTH] ?
        {state_reg.addr[HBP_AW-1:1], state_reg.ctrl[HBP_CTRL_SWAP]} : state_reg.addr;
    // Once ale has fallen the shared lines carry other traffic, shown here inverted
    assign bus.addr = state_reg.ale ? addr_pin : ~addr_pin;
    assign bus.ale = state_reg.ale;
    assign bus.cs_n = state_reg.cs_n;
    assign bus.rd_or_data_strobe_n = state_reg.strb_n;
    assign bus.wr_n_or_dir = state_reg.wr_pin;
    assign bus.mode = state_reg.ctrl[HBP_CTRL_MODE];
    assign bus.width = state_reg.ctrl[HBP_CTRL_WIDTH];
    assign bus.spi = state_reg.ctrl[HBP_CTRL_SPI];
    assign bus.host_d_o = state_reg.wdata;
    assign bus.host_d_oe = state_reg.d_oe;
    assign wb_dat_o = state_reg.dat;
    assign wb_ack_o = state_reg.ack;
    assign irq = |(state_reg.istat & state_reg.imask);
endmodule : hbp_host
`default_nettype wire

// ### bench/hbp_chk.sv
`timescale 1ns/100ps
`default_nettype none
module hbp_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic rd_or_data_strobe_n,
    input wire logic wr_n_or_dir,
    input wire logic mode,
    input wire logic width,
    input wire logic spi,
    input wire logic [1:0] dev_d_oe,
    input wire logic dev_rdy_oe,
    input wire logic rdy_n,
    input wire logic dev_int_oe
);
    logic act;
    logic rd_dir;
    // Strobe pin asserted, and direction of the access, per strobe style
    assign act = mode ? !rd_or_data_strobe_n : !(rd_or_data_strobe_n && wr_n_or_dir);
    assign rd_dir = mode ? wr_n_or_dir : !rd_or_data_strobe_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence strobe_gone;
        $fell(act);
    endsequence
    sequence rdy_back;
        ##[1:4] rdy_n;
    endsequence
    chk_rst_quiet: assert property (disable iff (1'b0) !reset_n |->
        !dev_rdy_oe && !dev_int_oe && dev_d_oe == 2'b00) else $error("outputs driven in reset");
    chk_rdy_desel: assert property (cs_n |-> !dev_rdy_oe)
        else $error("ready driven while deselected");
    chk_spi_quiet: assert property (spi |-> !dev_rdy_oe && dev_d_oe == 2'b00)
        else $error("parallel port active in serial mode");
    chk_rdy_follow: assert property ($fell(rdy_n) |-> act && $past(act) && $past(act, 2))
        else $error("ready without a settled strobe");
    chk_rdy_release: assert property (strobe_gone |-> rdy_back)
        else $error("ready not withdrawn after strobe release");
    chk_read_drive: assert property (dev_d_oe != 2'b00 |-> !cs_n && rd_dir && !rdy_n)
        else $error("data driven outside a ready read");
    chk_narrow_lane: assert property (!width && dev_d_oe != 2'b00 |-> dev_d_oe == 2'b01)
        else $error("narrow bus drives upper byte");
    chk_wide_lane: assert property (width && dev_d_oe != 2'b00 |-> dev_d_oe == 2'b11)
        else $error("wide bus lane enable wrong");
    chk_int_idle: assert property ($rose(reset_n) |-> !dev_int_oe [*5])
        else $error("interrupt driven after reset");
endmodule : hbp_chk
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import hbp_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic irq;
    logic [7:0] usr_addr;
    logic usr_rd;
    logic usr_wr;
    logic [15:0] usr_wdata;
    logic [1:0] usr_be;
    logic [15:0] usr_rdata;
    logic usr_ack = 1'b0;
    logic [7:0] irq_event = 8'h00;
    logic [1:0] dly = 2'd0;
    logic [15:0] umem [256];
    logic [15:0] ref_mem [256];
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    hbp_if u_hbp_if ();
    hbp_host u_hbp_host (.clk(clk), .reset_n(reset_n), .ce(ce), .bus(u_hbp_if.host),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq(irq));
    hbp_dev u_hbp_dev (.clk(clk), .reset_n(reset_n), .ce(ce), .bus(u_hbp_if.dev),
        .usr_addr(usr_addr), .usr_rd(usr_rd), .usr_wr(usr_wr), .usr_wdata(usr_wdata),
        .usr_be(usr_be), .usr_rdata(usr_rdata), .usr_ack(usr_ack), .irq_event(irq_event));
    hbp_chk u_hbp_chk (.clk(clk), .reset_n(reset_n), .cs_n(u_hbp_if.cs_n),
        .rd_or_data_strobe_n(u_hbp_if.rd_or_data_strobe_n), .wr_n_or_dir(u_hbp_if.wr_n_or_dir),
        .mode(u_hbp_if.mode), .width(u_hbp_if.width), .spi(u_hbp_if.spi),
        .dev_d_oe(u_hbp_if.dev_d_oe), .dev_rdy_oe(u_hbp_if.dev_rdy_oe), .rdy_n(u_hbp_if.rdy_n),
        .dev_int_oe(u_hbp_if.dev_int_oe));
    always #50 clk = ~clk;
    assign usr_rdata = umem[usr_addr];
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    // User register space answers after a random stall of zero to three cycles
    always @(posedge clk) begin
        usr_ack <= 1'b0;
        if ((usr_rd || usr_wr) && !usr_ack) begin
            if (dly == 2'd0) begin
                usr_ack <= 1'b1;
                dly <= 2'($urandom_range(3));
                if (usr_wr && usr_be[0]) umem[usr_addr][7:0] <= usr_wdata[7:0];
                if (usr_wr && usr_be[1]) umem[usr_addr][15:8] <= usr_wdata[15:8];
            end else begin
                dly <= dly - 2'd1;
            end
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do @(posedge clk); while (wb_ack !== 1'b1);
        q = wb_rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] junk;
        wb(1'b1, a, d, junk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic dev_acc(input logic w, input logic [8:0] a, input logic [15:0] d,
                           output logic [15:0] q);
        logic [31:0] t;
        wr(HBP_WB_ADDR, {23'h0, a});
        wr(HBP_WB_WDATA, {16'h0, d});
        wr(HBP_WB_CMD, {30'h0, ~w, 1'b1});
        t = 32'h1;
        while (t[0] === 1'b1) rd(HBP_WB_CMD, t);
        rd(HBP_WB_RDATA, t);
        q = t[15:0];
    endtask : dev_acc
    // Value seen on the data pins for register value v
    function automatic logic [15:0] lanes(input logic [15:0] v, input logic wd, input logic a0);
        if (wd) return a0 ? {v[7:0], v[15:8]} : v;
        return {8'h00, a0 ? v[15:8] : v[7:0]};
    endfunction : lanes
    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] w,
                                          input logic wd, input logic a0);
        if (wd) return a0 ? {w[7:0], w[15:8]} : w;
        return a0 ? {w[7:0], o[7:0]} : {o[15:8], w[7:0]};
    endfunction : merge
    initial begin
        logic [15:0] q;
        logic [15:0] d;
        logic [15:0] msk;
        logic [31:0] t;
        logic md;
        logic wd;
        logic mx;
        logic a0;
        logic w;
        logic [7:0] wa;
        void'($urandom(86236));
        for (int i = 0; i < 256; i++) begin
            umem[i] = 16'h0000;
            ref_mem[i] = 16'h0000;
        end
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            md = 1'($urandom);
            wd = 1'($urandom);
            mx = 1'($urandom);
            a0 = 1'($urandom);
            w = 1'($urandom);
            d = 16'($urandom);
            wa = (i == 1) ? 8'hFC : 8'($urandom_range(7));
            msk = wd ? 16'hFFFF : 16'h00FF;
            wr(HBP_WB_CTRL, {27'h0, mx, 1'b0, a0, wd, md});
            dev_acc(w, {wa, a0}, d, q);
            if (w) ref_mem[wa] = merge(ref_mem[wa], d, wd, a0);
            else check({16'h0, q & msk}, {16'h0, lanes(ref_mem[wa], wd, a0) & msk});
        end
        wr(HBP_WB_CTRL, 32'h3);
        wr(HBP_WB_IMASK, 32'h2);
        @(posedge clk);
        irq_event <= 8'h04;
        @(posedge clk);
        irq_event <= 8'h00;
        repeat (4) @(posedge clk);
        check({30'h0, u_hbp_if.dev_int_oe, irq}, 32'h0);
        dev_acc(1'b1, {HBP_DEV_IEN, 1'b0}, 16'h0004, q);
        repeat (4) @(posedge clk);
        check({30'h0, u_hbp_if.int_n, irq}, 32'h1);
        wr(HBP_WB_IMASK, 32'h0);
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
        dev_acc(1'b0, {HBP_DEV_IEN, 1'b0}, 16'h0000, q);
        check({16'h0, q}, 32'h4);
        dev_acc(1'b1, {HBP_DEV_ISTAT, 1'b0}, 16'h0004, q);
        repeat (4) @(posedge clk);
        wr(HBP_WB_ISTAT, 32'h3);
        check({30'h0, u_hbp_if.dev_int_oe, u_hbp_if.int_n}, 32'h1);
        dev_acc(1'b1, {HBP_DEV_ICTL, 1'b0}, 16'h0001, q);
        repeat (4) @(posedge clk);
        check({30'h0, u_hbp_if.dev_int_oe, u_hbp_if.int_n}, 32'h3);
        // An enabled event that comes while the clock enable is low is not seen
        ce <= 1'b0;
        irq_event <= 8'h04;
        @(posedge clk);
        ce <= 1'b1;
        irq_event <= 8'h00;
        repeat (4) @(posedge clk);
        check({30'h0, u_hbp_if.dev_int_oe, u_hbp_if.int_n}, 32'h3);
        // Serial mode: a parallel access must stay unanswered until reset
        wr(HBP_WB_CTRL, 32'h8);
        wr(HBP_WB_CMD, 32'h3);
        repeat (30) @(posedge clk);
        rd(HBP_WB_CMD, t);
        check({30'h0, t[0], u_hbp_if.rdy_n}, 32'h3);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        check({30'h0, u_hbp_if.dev_int_oe, u_hbp_if.dev_rdy_oe}, 32'h0);
        reset_n <= 1'b1;
        dev_acc(1'b0, {HBP_DEV_IEN, 1'b0}, 16'h0000, q);
        check({24'h0, q[7:0]}, 32'h0);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
